// File: rtl/pdoc_pkg.sv
/*
 package of constants for the detector / output configuration block.
 assumes: single 20 MHz system clock, all users reference names as pdoc_pkg::name.
*/
package pdoc_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int PD_MIN_PULSE_NS = 100;
	localparam int PD_MIN_CYC = (PD_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// serial transfer lengths
	// ----------------------------------------
	localparam logic [4:0] LEN_CFG = 5'h08;
	localparam logic [4:0] LEN_RDIV_SHORT = 5'h0F;
	localparam logic [4:0] LEN_NDIV = 5'h10;
	localparam logic [4:0] LEN_RDIV_LONG = 5'h18;
	localparam logic [4:0] LEN_MAX = 5'h1F;

	// ----------------------------------------
	// configuration register fields
	// ----------------------------------------
	localparam int CFG_POL = 7;
	localparam int CFG_SEL = 6;
	localparam int CFG_LDE = 5;
	localparam int CFG_OSC_HI = 4;
	localparam int CFG_OSC_LO = 2;
	localparam int CFG_FVE = 1;
	localparam int CFG_FRE = 0;
	localparam logic [7:0] CFG_RESET = 8'h10;

	// ----------------------------------------
	// reference output select codes
	// ----------------------------------------
	localparam logic [2:0] OSC_OFF = 3'h0;
	localparam logic [2:0] OSC_DIV1 = 3'h1;
	localparam logic [2:0] OSC_DIV2 = 3'h2;
	localparam logic [2:0] OSC_DIV4 = 3'h3;
	localparam logic [2:0] OSC_DIV8A = 3'h4;
	localparam logic [2:0] OSC_DIV8B = 3'h6;

	// ----------------------------------------
	// divider widths and resets
	// ----------------------------------------
	localparam int RDIV_W = 15;
	localparam int NDIV_W = 16;
	localparam logic [14:0] RDIV_RESET = 15'h0001;
	localparam logic [15:0] NDIV_RESET = 16'h0028;
	localparam int SYNC_N = 5;
endpackage

// File: rtl/pdoc_phase_det.sv
/*
 phase/frequency detector with single- and double-ended outputs and lock indicator.
 assumes: r_evt and v_evt are one-cycle pulses on clk; jam clears detector state.
*/
`timescale 1ns/1ps
module pdoc_phase_det (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic jam,
	input wire logic r_evt,
	input wire logic v_evt,
	input wire logic detector_polarity,
	input wire logic sel,
	input wire logic lock_en,
	output logic ref_pump_out,
	output logic vco_pump_out,
	output logic se_out,
	output logic se_oe,
	output logic lock_out
);
	// ----------------------------------------
	// lead flags
	// ----------------------------------------
	logic r_q, v_q;
	logic [3:0] hold_q;
	wire both = r_q & v_q;
	wire hold_done = (hold_q == 4'(pdoc_pkg::PD_MIN_CYC - 1));
	wire v_low = detector_polarity ? r_q : v_q;
	wire r_low = detector_polarity ? v_q : r_q;

	// both flags stay set a minimum width, removing the dead zone
	always_ff @(posedge clk) begin
		if (sys_rst || jam) begin
			r_q <= 1'b0;
			v_q <= 1'b0;
			hold_q <= 4'h0;
		end else if (both && hold_done) begin
			r_q <= r_evt;
			v_q <= v_evt;
			hold_q <= 4'h0;
		end else begin
			r_q <= r_q | r_evt;
			v_q <= v_q | v_evt;
			hold_q <= both ? hold_q + 4'h1 : 4'h0;
		end
	end

	// ----------------------------------------
	// output stage
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vco_pump_out <= 1'b1;
			ref_pump_out <= 1'b1;
			se_out <= 1'b1;
			se_oe <= 1'b0;
			lock_out <= 1'b0;
		end else begin
			vco_pump_out <= sel | ~v_low;
			ref_pump_out <= sel | ~r_low;
			se_oe <= sel & (r_q | v_q);
			se_out <= detector_polarity ^ (r_q & ~v_q);
			lock_out <= lock_en & ~(r_q | v_q);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_both_set;
		$rose(both);
	endsequence
	sequence s_both_held;
		both [*2] ##1 !both;
	endsequence
	property p_min_pulse;
		@(posedge clk) disable iff (sys_rst || jam) s_both_set |-> s_both_held;
	endproperty
	a_min_pulse: assert property (p_min_pulse) else $error("min pulse width wrong");
	property p_vco_lead;
		@(posedge clk) disable iff (sys_rst) !detector_polarity && !sel && v_q && !r_q |=> !vco_pump_out && ref_pump_out;
	endproperty
	a_vco_lead: assert property (p_vco_lead) else $error("vco lead pulse wrong");
	property p_pol_swap;
		@(posedge clk) disable iff (sys_rst) detector_polarity && !sel && v_q && !r_q |=> vco_pump_out && !ref_pump_out;
	endproperty
	a_pol_swap: assert property (p_pol_swap) else $error("polarity swap wrong");
	property p_sel_static;
		@(posedge clk) disable iff (sys_rst) sel |=> vco_pump_out && ref_pump_out;
	endproperty
	a_sel_static: assert property (p_sel_static) else $error("pumps not static high");
	property p_se_hiz;
		@(posedge clk) disable iff (sys_rst) !sel || !(r_q || v_q) |=> !se_oe;
	endproperty
	a_se_hiz: assert property (p_se_hiz) else $error("single-ended not released");
	property p_lock_low;
		@(posedge clk) disable iff (sys_rst) (r_q ^ v_q) |=> !lock_out;
	endproperty
	a_lock_low: assert property (p_lock_low) else $error("lock high out of phase");
endmodule

// File: rtl/pdoc_top.sv
/*
 serial-programmed configuration, dividers and output control of a pll synthesizer.
 assumes: serial pins, reference and vco inputs are asynchronous to clk and
 much slower than 20 MHz; a three-state pad merges se_detector_out with its enable.
*/
`timescale 1ns/1ps
// Overview of operation
// - polarity low: leading feedback pulses vco side low
// - locked: both pump outputs pulse low together briefly
// - polarity bit inverts and swaps detectors; resets low
// - select high: single-ended active, pumps high
// - lock indicator high when matched, pulses otherwise
// - lock indicator low unless enabled; enable resets low
// - three select bits pick reference output divider
// - reference output select resets to divide-by-8
// - two bits gate divided outputs, reset low
// - eight clocks store configuration byte only
// - 24 or 15 clocks store reference divider
// - sixteen clocks store feedback divider, jam counters
// - single-ended output pulses out of lock, else released
// - serial data out shifts on falling clock
// - each reference rising edge decrements reference counter, or reloads it from the divider at 1 or 0
// - enabled divided outputs idle low, pulse high
module pdoc_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ser_clk,
	input wire logic ser_data_in,
	input wire logic ser_enable_n,
	input wire logic ref_osc_in,
	input wire logic feedback_in,
	output logic ser_data_out,
	output logic ref_clock_out,
	output logic ref_divided_out,
	output logic feedback_divided_out,
	output logic lock_indicator,
	output logic ref_side_pump_out,
	output logic vco_side_pump_out,
	output logic single_ended_detector_out,
	output logic single_ended_detector_oe
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NS = pdoc_pkg::SYNC_N;
	// frame pin idles high: low reset stages would fake a transfer end
	localparam logic [NS-1:0] SYNC_IDLE = 5'h04;
	wire [NS-1:0] pins = {feedback_in, ref_osc_in, ser_enable_n, ser_data_in, ser_clk};
	logic [NS-1:0] meta_q, sync_q, prev_q;

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					meta_q[gi] <= SYNC_IDLE[gi];
					sync_q[gi] <= SYNC_IDLE[gi];
					prev_q[gi] <= SYNC_IDLE[gi];
				end else begin
					meta_q[gi] <= pins[gi];
					sync_q[gi] <= meta_q[gi];
					prev_q[gi] <= sync_q[gi];
				end
			end
		end
	endgenerate

	wire sclk_rise = sync_q[0] & ~prev_q[0];
	wire sclk_fall = ~sync_q[0] & prev_q[0];
	wire sdin = sync_q[1];
	wire enb_n = sync_q[2];
	wire enb_fall = ~sync_q[2] & prev_q[2];
	wire xfer_end = sync_q[2] & ~prev_q[2];
	wire ref_rise = sync_q[3] & ~prev_q[3];
	wire fb_rise = sync_q[4] & ~prev_q[4];

	// ----------------------------------------
	// serial shift register
	// ----------------------------------------
	logic [23:0] shift_q;
	logic [4:0] bits_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_q <= 24'h000000;
			bits_q <= 5'h00;
		end else if (enb_fall) begin
			bits_q <= 5'h00;
		end else if (!enb_n && sclk_rise) begin
			shift_q <= {shift_q[22:0], sdin};
			bits_q <= (bits_q == pdoc_pkg::LEN_MAX) ? bits_q : bits_q + 5'h01;
		end
	end

	// half stage so the output changes on the falling edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ser_data_out <= 1'b0;
		end else if (sclk_fall) begin
			ser_data_out <= shift_q[15];
		end
	end

	// ----------------------------------------
	// destination decode
	// ----------------------------------------
	wire wr_cfg = xfer_end && bits_q == pdoc_pkg::LEN_CFG;
	wire wr_rdiv = xfer_end && (bits_q == pdoc_pkg::LEN_RDIV_SHORT
		|| bits_q == pdoc_pkg::LEN_RDIV_LONG);
	wire wr_ndiv = xfer_end && bits_q == pdoc_pkg::LEN_NDIV;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] synth_config_q;
	logic [pdoc_pkg::RDIV_W-1:0] rdiv_q;
	logic [pdoc_pkg::NDIV_W-1:0] ndiv_q;

	// other lengths are ignored: a garbled transfer must not retune the loop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			synth_config_q <= pdoc_pkg::CFG_RESET;
			rdiv_q <= pdoc_pkg::RDIV_RESET;
			ndiv_q <= pdoc_pkg::NDIV_RESET;
		end else begin
			if (wr_cfg) begin
				synth_config_q <= shift_q[7:0];
			end
			if (wr_rdiv) begin
				rdiv_q <= shift_q[pdoc_pkg::RDIV_W-1:0];
			end
			if (wr_ndiv) begin
				ndiv_q <= shift_q[pdoc_pkg::NDIV_W-1:0];
			end
		end
	end

	wire detector_polarity = synth_config_q[pdoc_pkg::CFG_POL];
	wire det_sel = synth_config_q[pdoc_pkg::CFG_SEL];
	wire lock_en = synth_config_q[pdoc_pkg::CFG_LDE];
	wire [2:0] osc_sel = synth_config_q[pdoc_pkg::CFG_OSC_HI:pdoc_pkg::CFG_OSC_LO];
	wire fv_en = synth_config_q[pdoc_pkg::CFG_FVE];
	wire fr_en = synth_config_q[pdoc_pkg::CFG_FRE];

	// ----------------------------------------
	// reference and feedback counters
	// ----------------------------------------
	logic [pdoc_pkg::RDIV_W-1:0] rcnt_q;
	logic [pdoc_pkg::NDIV_W-1:0] ncnt_q;
	wire r_wrap = rcnt_q <= pdoc_pkg::RDIV_W'(1);
	wire n_wrap = ncnt_q <= pdoc_pkg::NDIV_W'(1);
	wire r_evt = ref_rise & r_wrap & ~wr_ndiv;
	wire v_evt = fb_rise & n_wrap & ~wr_ndiv;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rcnt_q <= pdoc_pkg::RDIV_RESET;
			ncnt_q <= pdoc_pkg::NDIV_RESET;
		end else if (wr_ndiv) begin
			rcnt_q <= rdiv_q;
			ncnt_q <= shift_q[pdoc_pkg::NDIV_W-1:0];
		end else begin
			if (ref_rise) begin
				rcnt_q <= r_wrap ? rdiv_q : rcnt_q - pdoc_pkg::RDIV_W'(1);
			end
			if (fb_rise) begin
				ncnt_q <= n_wrap ? ndiv_q : ncnt_q - pdoc_pkg::NDIV_W'(1);
			end
		end
	end

	// ----------------------------------------
	// divided outputs
	// ----------------------------------------
	logic fr_q, fv_q;

	// one input period wide high pulse, low otherwise
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fr_q <= 1'b0;
			fv_q <= 1'b0;
		end else begin
			fr_q <= fr_en & (r_evt | (fr_q & ~ref_rise));
			fv_q <= fv_en & (v_evt | (fv_q & ~fb_rise));
		end
	end
	assign ref_divided_out = fr_q;
	assign feedback_divided_out = fv_q;

	// ----------------------------------------
	// reference output prescaler
	// ----------------------------------------
	logic [3:0] pre_q;
	logic ref_clock_out_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_q <= 4'h0;
		end else if (ref_rise) begin
			pre_q <= pre_q + 4'h1;
		end
	end

	// codes 110 and 111 alias divide-by-8 and divide-by-16
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ref_clock_out_q <= 1'b0;
		end else begin
			case (osc_sel)
				pdoc_pkg::OSC_OFF: ref_clock_out_q <= 1'b0;
				pdoc_pkg::OSC_DIV1: ref_clock_out_q <= sync_q[3];
				pdoc_pkg::OSC_DIV2: ref_clock_out_q <= pre_q[0];
				pdoc_pkg::OSC_DIV4: ref_clock_out_q <= pre_q[1];
				pdoc_pkg::OSC_DIV8A, pdoc_pkg::OSC_DIV8B: ref_clock_out_q <= pre_q[2];
				default: ref_clock_out_q <= pre_q[3];
			endcase
		end
	end
	assign ref_clock_out = ref_clock_out_q;

	// ----------------------------------------
	// phase detectors
	// ----------------------------------------
	pdoc_phase_det u_det (
		.clk(clk),
		.sys_rst(sys_rst),
		.jam(wr_ndiv),
		.r_evt(r_evt),
		.v_evt(v_evt),
		.detector_polarity(detector_polarity),
		.sel(det_sel),
		.lock_en(lock_en),
		.ref_pump_out(ref_side_pump_out),
		.vco_pump_out(vco_side_pump_out),
		.se_out(single_ended_detector_out),
		.se_oe(single_ended_detector_oe),
		.lock_out(lock_indicator)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_cfg_store;
		@(posedge clk) disable iff (sys_rst) wr_cfg |=> synth_config_q == $past(shift_q[7:0]) && $stable(ndiv_q);
	endproperty
	a_cfg_store: assert property (p_cfg_store) else $error("config byte not stored");
	property p_rdiv_store;
		@(posedge clk) disable iff (sys_rst) wr_rdiv |=> rdiv_q == $past(shift_q[14:0]) && $stable(synth_config_q);
	endproperty
	a_rdiv_store: assert property (p_rdiv_store) else $error("ref divider not stored");
	property p_jam;
		@(posedge clk) disable iff (sys_rst) wr_ndiv |=> ncnt_q == $past(shift_q[15:0]) && rcnt_q == rdiv_q;
	endproperty
	a_jam: assert property (p_jam) else $error("counters not jam loaded");
	property p_cfg_reset;
		@(posedge clk) sys_rst |=> synth_config_q == pdoc_pkg::CFG_RESET && !lock_indicator && !fr_q && !fv_q;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("reset defaults wrong");
	property p_lock_off;
		@(posedge clk) disable iff (sys_rst) !lock_en [*2] |-> !lock_indicator;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("lock driven while disabled");
	property p_div_off;
		@(posedge clk) disable iff (sys_rst) !fv_en |=> !feedback_divided_out;
	endproperty
	a_div_off: assert property (p_div_off) else $error("feedback output not static low");
	property p_fr_off;
		@(posedge clk) disable iff (sys_rst) !fr_en |=> !ref_divided_out;
	endproperty
	a_fr_off: assert property (p_fr_off) else $error("reference output not static low");
	property p_ref_clock_out_off;
		@(posedge clk) disable iff (sys_rst) osc_sel == 3'h0 |=> !ref_clock_out;
	endproperty
	a_ref_clock_out_off: assert property (p_ref_clock_out_off) else $error("ref output not static low");
	property p_rdec;
		@(posedge clk) disable iff (sys_rst) ref_rise && !r_wrap && !wr_ndiv |=> rcnt_q == $past(rcnt_q) - 15'h0001;
	endproperty
	a_rdec: assert property (p_rdec) else $error("ref counter not decremented");
	property p_ndec;
		@(posedge clk) disable iff (sys_rst)
			fb_rise && !n_wrap && !wr_ndiv |=> ncnt_q == $past(ncnt_q) - 16'h0001;
	endproperty
	a_ndec: assert property (p_ndec) else $error("feedback counter not decremented");

	// ----------------------------------------
	// checks: serial port and registers
	// ----------------------------------------
	property p_ndiv_store;
		@(posedge clk) disable iff (sys_rst)
			wr_ndiv |=> ndiv_q == $past(shift_q[15:0]) && $stable(synth_config_q) && $stable(rdiv_q);
	endproperty
	a_ndiv_store: assert property (p_ndiv_store) else $error("feedback divider not stored");
	// a garbled frame length must leave every register alone
	property p_no_write;
		@(posedge clk) disable iff (sys_rst)
			xfer_end && !(wr_cfg || wr_rdiv || wr_ndiv) |=> $stable(synth_config_q) && $stable(rdiv_q) && $stable(ndiv_q);
	endproperty
	a_no_write: assert property (p_no_write) else $error("register written by bad length");
	property p_ser_out;
		@(posedge clk) disable iff (sys_rst) sclk_fall |=> ser_data_out == $past(shift_q[15]);
	endproperty
	a_ser_out: assert property (p_ser_out) else $error("serial out not shifted on fall");

	// ----------------------------------------
	// checks: divided outputs
	// ----------------------------------------
	property p_fr_pulse;
		@(posedge clk) disable iff (sys_rst) fr_en && r_evt |=> ref_divided_out;
	endproperty
	a_fr_pulse: assert property (p_fr_pulse) else $error("reference pulse missing");
	property p_fv_pulse;
		@(posedge clk) disable iff (sys_rst) fv_en && v_evt |=> feedback_divided_out;
	endproperty
	a_fv_pulse: assert property (p_fv_pulse) else $error("feedback pulse missing");
endmodule

// File: dv/pdoc_serial_host.sv
/*
 serial-port controller model that writes the block's registers.
 assumes: clk is the system clock; pins change only at its falling edge.
*/
`timescale 1ns/1ps
module pdoc_serial_host (
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data_in,
	output logic ser_enable_n
);
	// ----------------------------------------
	// pins idle
	// ----------------------------------------
	// serial clock stands still low between frames
	initial begin
		ser_clk = 1'b0;
		ser_data_in = 1'b0;
		ser_enable_n = 1'b1;
	end

	// ----------------------------------------
	// one framed transfer, msb first
	// ----------------------------------------
	// bit count picks the register: 8, 15/24 or 16
	task automatic send(input logic [23:0] val, input int nbits);
		int i;
		ser_enable_n <= 1'b0;
		for (i = nbits - 1; i >= 0; i--) begin
			ser_data_in <= val[i];
			repeat (4) @(negedge clk);
			ser_clk <= 1'b1;
			repeat (4) @(negedge clk);
			ser_clk <= 1'b0;
		end
		repeat (4) @(negedge clk);
		ser_enable_n <= 1'b1;
		// released data shows no stale bit
		ser_data_in <= ~val[0];
		repeat (8) @(negedge clk);
	endtask
endmodule

// File: dv/tb_pdoc_top.sv
/*
 self-checking bench: register writes over the serial port, output checks.
 assumes: reference and feedback inputs far slower than clk.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %0d expected %0d", $time, (a), (b)); end end
module tb_pdoc_top;
	logic clk, sys_rst, ref_osc_in, feedback_in, same;
	logic ser_clk, ser_data_in, ser_enable_n, ser_data_out, quiet;
	logic ref_clock_out, ref_divided_out, feedback_divided_out, lock_indicator;
	logic ref_side_pump_out, vco_side_pump_out, single_ended_detector_out, single_ended_detector_oe;
	int err_count, cmp_count, rc, fc, rl, vl, dif, ll, oe, sebad, i, p, s;
	int dv[8] = '{0, 1, 2, 4, 8, 16, 8, 16};
	wire [2:0] mon = {ref_clock_out, ref_divided_out, feedback_divided_out};

	pdoc_top pdoc_top_i (.clk(clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data_in(ser_data_in),
		.ser_enable_n(ser_enable_n), .ref_osc_in(ref_osc_in), .feedback_in(feedback_in),
		.ser_data_out(ser_data_out),
		.ref_clock_out(ref_clock_out), .ref_divided_out(ref_divided_out),
		.feedback_divided_out(feedback_divided_out), .lock_indicator(lock_indicator),
		.ref_side_pump_out(ref_side_pump_out), .vco_side_pump_out(vco_side_pump_out),
		.single_ended_detector_out(single_ended_detector_out),
		.single_ended_detector_oe(single_ended_detector_oe));
	pdoc_serial_host pdoc_serial_host_i (.clk(clk), .ser_clk(ser_clk), .ser_data_in(ser_data_in),
		.ser_enable_n(ser_enable_n));

	// ----------------------------------------
	// clock and input waveforms
	// ----------------------------------------
	initial clk = 1'b0;
	always #25 clk = ~clk;
	// ref period 10 clk; feedback 8 clk, or a copy of ref for lock
	always @(negedge clk) begin
		rc <= (rc + 1) % 10;
		fc <= (fc + 1) % 8;
		// held low until the reset checks are done, so no edge reaches them
		ref_osc_in <= !quiet && rc < 5;
		feedback_in <= !quiet && (same ? (rc < 5) : (fc < 4));
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [23:0] cf(input logic detector_polarity, input logic sel, input logic lock_output_enable,
		input logic [2:0] osc, input logic [1:0] en);
		cf = {16'h0000, detector_polarity, sel, lock_output_enable, osc, en};
	endfunction

	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// rise-to-rise period of mon[k]; zero means no rise at all
	task automatic per(input int k, input int exp);
		int t, n, t0;
		logic q;
		t = 0;
		n = 0;
		t0 = 0;
		q = mon[k];
		while (n < 2 && t < 3000) begin
			@(negedge clk);
			t++;
			if (mon[k] === 1'b1 && q === 1'b0) begin
				n++;
				if (n == 2) `CHK(t - t0, exp)
				else t0 = t;
			end
			q = mon[k];
		end
		if (exp == 0) `CHK(n, 0)
		else if (n < 2) begin
			err_count++;
			$display("unexpected at %0t: no pulse", $time);
			give_verdict;
		end
	endtask

	task automatic watch(input int n, input logic se_exp);
		rl = 0;
		vl = 0;
		dif = 0;
		ll = 0;
		oe = 0;
		sebad = 0;
		repeat (n) begin
			@(negedge clk);
			rl += (ref_side_pump_out === 1'b0);
			vl += (vco_side_pump_out === 1'b0);
			dif += (ref_side_pump_out !== vco_side_pump_out);
			ll += (lock_indicator === 1'b0);
			oe += (single_ended_detector_oe === 1'b1);
			sebad += (single_ended_detector_oe === 1'b1 && single_ended_detector_out !== se_exp);
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		err_count = 0;
		cmp_count = 0;
		rc = 0;
		fc = 0;
		same = 1'b1;
		quiet = 1'b1;
		ref_osc_in = 1'b0;
		feedback_in = 1'b0;
		sys_rst = 1'b1; // bench resets as the controller must
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(lock_indicator, 1'b0)
		`CHK({ref_side_pump_out, vco_side_pump_out, single_ended_detector_oe}, 3'h6)
		`CHK({ref_divided_out, feedback_divided_out}, 2'h0)
		quiet <= 1'b0;
		per(2, 80);
		for (i = 0; i < 8; i++) begin
			pdoc_serial_host_i.send(cf(1'b0, 1'b0, 1'b0, i[2:0], 2'h0), 8);
			per(2, dv[i] * 10);
		end
		// nine clocks match no register
		pdoc_serial_host_i.send(cf(1'b0, 1'b0, 1'b0, 3'h1, 2'h0), 9);
		per(2, 160);
		per(1, 0);
		per(0, 0);
		pdoc_serial_host_i.send(24'h000028, 15);
		pdoc_serial_host_i.send(24'h000028, 16);
		`CHK(ser_data_out, 1'b0)
		pdoc_serial_host_i.send(cf(1'b0, 1'b0, 1'b1, 3'h4, 2'h3), 8);
		repeat (100) @(negedge clk);
		watch(2000, 1'b0);
		`CHK(dif, 0)
		`CHK(vl > 0, 1'b1)
		`CHK(ll < 40, 1'b1)
		per(1, 400);
		per(0, 400);
		same = 1'b0;
		repeat (400) @(negedge clk);
		per(0, 320);
		// feedback now faster than reference
		for (s = 0; s < 2; s++) begin
			for (p = 0; p < 2; p++) begin
				pdoc_serial_host_i.send(cf(p[0], s[0], 1'b1, 3'h4, 2'h3), 8);
				watch(2000, p[0]);
				if (s == 0) begin
					`CHK(oe, 0)
					`CHK(p == 1 ? rl > vl : vl > rl, 1'b1)
					`CHK(ll > 0, 1'b1)
				end else begin
					`CHK(rl + vl, 0)
					`CHK(oe > 0, 1'b1)
					`CHK(sebad, 0)
				end
			end
		end
		// lock off, of the two divided outputs only the reference one enabled
		pdoc_serial_host_i.send(cf(1'b0, 1'b0, 1'b0, 3'h4, 2'h1), 8);
		watch(500, 1'b0);
		`CHK(ll, 500)
		per(0, 0);
		per(1, 400);
		// long form: low 15 bits give 20, bit 15 set for the serial out
		pdoc_serial_host_i.send(24'hA58014, 24);
		repeat (500) @(negedge clk);
		per(1, 200);
		`CHK(ser_data_out, 1'b1)
		give_verdict;
	end
endmodule
